// file: pspd_pkg.sv
// Shared constants, register map and carrier types of the divider loader.
// Assumes a single clock domain; every user writes pspd_pkg::name.
package pspd_pkg;
  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] PSPD_OFS_CTRL    = 8'h00;
  localparam logic [7:0] PSPD_OFS_STATUS  = 8'h04;
  localparam logic [7:0] PSPD_OFS_SETTING = 8'h08;
  localparam logic [7:0] PSPD_OFS_IRQ_ST  = 8'h0C;
  localparam logic [7:0] PSPD_OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] PSPD_OFS_IRQ_EN  = 8'h14;
  // Field positions.
  localparam int unsigned PSPD_CTRL_PRESC  = 0;
  localparam int unsigned PSPD_IRQ_LOAD    = 0;
  localparam int unsigned PSPD_IRQ_LOCK    = 1;
  localparam int unsigned PSPD_IRQ_UNLOCK  = 2;
  localparam int unsigned PSPD_IRQ_IGNORED = 3;
  localparam int unsigned PSPD_IRQ_W       = 4;
  // Nibbles in one load sequence.
  localparam logic [2:0] PSPD_NIBBLES = 3'h5;
  localparam logic [2:0] PSPD_LAST_NIB = 3'h4;
  // Reference divider reload values (ratio minus one).
  localparam logic [10:0] PSPD_REF_1024 = 11'h3FF;
  localparam logic [10:0] PSPD_REF_1000 = 11'h3E7;
  localparam logic [10:0] PSPD_REF_100  = 11'h063;
  localparam logic [10:0] PSPD_REF_20   = 11'h013;
  // Loaded setting: swallow digit, BCD N digits, reference select.
  typedef struct packed {
    logic [3:0] swallow;
    logic [3:0] units;
    logic [3:0] tens;
    logic [3:0] hundreds;
    logic [1:0] thousands;
    logic [1:0] ref_sel;
  } pspd_setting_type;
  // After reset N is 20, A is 0 and the ratio is 1024.
  localparam pspd_setting_type PSPD_SETTING_RST = '{
    swallow: 4'h0, units: 4'h0, tens: 4'h2, hundreds: 4'h0,
    thousands: 2'h0, ref_sel: 2'h0};
  // Phase detector states.
  typedef enum logic [1:0] {
    PSPD_PD_IDLE = 2'b00,
    PSPD_PD_LEAD = 2'b01,
    PSPD_PD_LAG  = 2'b10
  } pspd_pd_type;
  // Converts the BCD value of N to binary.
  function automatic logic [11:0] pspd_bcd2bin(input pspd_setting_type s);
    pspd_bcd2bin = {8'h00, s.units} + {8'h00, s.tens} * 12'h00A
                 + {8'h00, s.hundreds} * 12'h064 + {10'h000, s.thousands} * 12'h3E8;
  endfunction
endpackage

// file: pspd_loader.sv
// Nibble loader: five BCD nibbles framed by the latch reset line.
// Assumes the read clock, latch reset and data lines are synchronous to clk_in.
`timescale 1ns/10ps
module pspd_loader (
  input  wire logic                       clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       clk_en_in,
  input  wire logic                       latch_reset_in,
  input  wire logic                       data_read_clock_in,
  input  wire logic [3:0]                 data_in,
  output pspd_pkg::pspd_setting_type      setting_out,
  output logic                            load_out,
  output logic                            ignored_out,
  output logic [2:0]                      count_out
);
  logic                       rclk_q;
  logic                       lrst_q;
  logic                       fall;
  logic                       restart;
  pspd_pkg::pspd_setting_type shadow_q;
  // Falling read clock edges count only while the latch reset is low.
  assign fall    = rclk_q & ~data_read_clock_in & ~latch_reset_in;
  assign restart = lrst_q & ~latch_reset_in;
  // Previous levels for edge detection.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rclk_q <= 1'b1;
      lrst_q <= 1'b0;
    end else if (clk_en_in) begin
      rclk_q <= data_read_clock_in;
      lrst_q <= latch_reset_in;
    end
  end
  // Capture sequence; the shadow keeps the old setting live until the fifth nibble.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_out   <= pspd_pkg::PSPD_NIBBLES;
      shadow_q    <= pspd_pkg::PSPD_SETTING_RST;
      setting_out <= pspd_pkg::PSPD_SETTING_RST;
      load_out    <= 1'b0;
      ignored_out <= 1'b0;
    end else if (clk_en_in) begin
      load_out    <= 1'b0;
      ignored_out <= 1'b0;
      if (restart) begin
        count_out <= 3'h0;
      end else if (fall && count_out < pspd_pkg::PSPD_NIBBLES) begin
        count_out <= count_out + 3'h1;
        case (count_out)
          3'h0: shadow_q.swallow  <= data_in;
          3'h1: shadow_q.units    <= data_in;
          3'h2: shadow_q.tens     <= data_in;
          3'h3: shadow_q.hundreds <= data_in;
          default: begin
            setting_out           <= shadow_q;
            setting_out.thousands <= data_in[1:0];
            setting_out.ref_sel   <= data_in[3:2];
            load_out              <= 1'b1;
          end
        endcase
      end else if (fall) begin
        ignored_out <= 1'b1;
      end
    end
  end
endmodule

// file: pspd_phase_det.sv
// Three-state phase detector core: remembers which edge came first.
// Assumes one-cycle pulses for the divided input and the reference.
`timescale 1ns/10ps
module pspd_phase_det (
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  fin_pulse_in,
  input  wire logic                  ref_pulse_in,
  output pspd_pkg::pspd_pd_type      state_out
);
  // Coincident pulses leave the detector idle, which reads as in phase.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_out <= pspd_pkg::PSPD_PD_IDLE;
    end else if (clk_en_in) begin
      case (state_out)
        pspd_pkg::PSPD_PD_IDLE: begin
          if (fin_pulse_in && !ref_pulse_in) begin
            state_out <= pspd_pkg::PSPD_PD_LEAD;
          end else if (ref_pulse_in && !fin_pulse_in) begin
            state_out <= pspd_pkg::PSPD_PD_LAG;
          end
        end
        pspd_pkg::PSPD_PD_LEAD: begin
          if (ref_pulse_in) begin
            state_out <= pspd_pkg::PSPD_PD_IDLE;
          end
        end
        pspd_pkg::PSPD_PD_LAG: begin
          if (fin_pulse_in) begin
            state_out <= pspd_pkg::PSPD_PD_IDLE;
          end
        end
        default: state_out <= pspd_pkg::PSPD_PD_IDLE;
      endcase
    end
  end
endmodule

// file: pspd_top.sv
// Top of the synthesizer digital core: loader, dividers, phase detector,
// lock and test outputs, and a classic Wishbone register slave.
// Assumes all pins are synchronous to clk_in, which also serves as the reference.
//
// Contract
// - Phase output drives high on lead, low on lag, floats when in phase.
// - Lock pin low while phase output floats, released while it drives.
// - Test high routes divider output to phase pin, reference to lock pin.
// - Modulus control output picks divide by ten or eleven in the prescaler.
// - After latch reset falls, five falling read clocks capture one nibble each.
// - Whole setting applies at fifth falling edge; later read clocks are ignored.
// - With latch reset high, read clock and data lines are ignored.
// - With prescaler, overall ratio is swallow digit plus ten times N.
// - Without prescaler, ratio is N alone and swallow digit is unused.
// - Two select bits choose crystal ratio 1024, 1000, 100 or 20.
// - Swallow digit is 0 to 9; N is BCD 20 to 3999 in fourteen bits.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/10ps
module pspd_top #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  input  wire logic              clk_en_in,
  input  wire logic              latch_reset_in,
  input  wire logic              data_read_clock_in,
  input  wire logic [3:0]        data_in,
  input  wire logic              test_in,
  input  wire logic              count_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADDR_W-1:0] wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  output logic                   phase_detector_out,
  output logic                   phase_detector_oe_n_out,
  output logic                   lock_oe_n_out,
  output logic                   modulus_control_out,
  output logic                   irq_out
);
  // Loader outputs.
  pspd_pkg::pspd_setting_type setting;
  logic                       load_pulse;
  logic                       ignored_pulse;
  logic [2:0]                 nib_count;
  // Divider chain state.
  logic                       cin_q;
  logic                       cin_rise;
  logic [11:0]                prog_cnt_q;
  logic [11:0]                n_bin;
  logic [3:0]                 swallow_q;
  logic                       fin_pulse_q;
  logic [10:0]                ref_cnt_q;
  logic [10:0]                ref_reload;
  logic                       ref_pulse_q;
  // Phase detector and lock tracking.
  pspd_pkg::pspd_pd_type      pd_state;
  logic                       locked_q;
  logic                       lock_gain;
  logic                       lock_loss;
  // Registers.
  logic                       presc_en_q;
  logic                       loaded_q;
  logic [pspd_pkg::PSPD_IRQ_W-1:0] irq_st_q;
  logic [pspd_pkg::PSPD_IRQ_W-1:0] irq_st_d;
  logic [pspd_pkg::PSPD_IRQ_W-1:0] irq_en_q;
  logic [pspd_pkg::PSPD_IRQ_W-1:0] irq_clr;
  logic [pspd_pkg::PSPD_IRQ_W-1:0] irq_ev;
  logic                       bus_req;
  logic                       bus_wr;
  logic [31:0]                rd_d;

  // Nibble capture and the two-stage setting latch.
  pspd_loader u_loader (
    .clk_in             (clk_in),
    .nrst_in            (nrst_in),
    .clk_en_in          (clk_en_in),
    .latch_reset_in     (latch_reset_in),
    .data_read_clock_in (data_read_clock_in),
    .data_in            (data_in),
    .setting_out        (setting),
    .load_out           (load_pulse),
    .ignored_out        (ignored_pulse),
    .count_out          (nib_count)
  );

  // Edge order of the two divided signals.
  pspd_phase_det u_pd (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .clk_en_in    (clk_en_in),
    .fin_pulse_in (fin_pulse_q),
    .ref_pulse_in (ref_pulse_q),
    .state_out    (pd_state)
  );

  // The BCD value is converted once; digits above nine are not clamped,
  // so software must keep N within 20 to 3999 and the swallow digit below ten.
  assign n_bin = pspd_pkg::pspd_bcd2bin(setting);

  // Reference ratio from the two select bits.
  always_comb begin
    case (setting.ref_sel)
      2'b00:   ref_reload = pspd_pkg::PSPD_REF_1024;
      2'b01:   ref_reload = pspd_pkg::PSPD_REF_1000;
      2'b10:   ref_reload = pspd_pkg::PSPD_REF_100;
      default: ref_reload = pspd_pkg::PSPD_REF_20;
    endcase
  end

  // Count input edge detection.
  assign cin_rise = count_in & ~cin_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cin_q <= 1'b0;
    end else if (clk_en_in) begin
      cin_q <= count_in;
    end
  end

  // Program divider with swallow counter. After each terminal count the first A
  // prescaler periods run at eleven and the rest at ten, giving 11A + 10(N - A).
  // A new setting takes hold at the next terminal count, so no period is cut short.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prog_cnt_q  <= 12'h000;
      swallow_q   <= 4'h0;
      fin_pulse_q <= 1'b0;
    end else if (clk_en_in) begin
      fin_pulse_q <= 1'b0;
      if (cin_rise) begin
        if (prog_cnt_q == 12'h000) begin
          prog_cnt_q  <= n_bin - 12'h001;
          fin_pulse_q <= 1'b1;
          swallow_q   <= presc_en_q ? setting.swallow : 4'h0;
        end else begin
          prog_cnt_q <= prog_cnt_q - 12'h001;
          if (swallow_q != 4'h0) begin
            swallow_q <= swallow_q - 4'h1;
          end
        end
      end
    end
  end

  // Modulus control is high (divide by eleven) while swallow periods remain.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      modulus_control_out <= 1'b0;
    end else if (clk_en_in) begin
      modulus_control_out <= presc_en_q && (swallow_q != 4'h0);
    end
  end

  // Reference divider counts clk_in cycles and emits a one-cycle pulse.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_cnt_q   <= pspd_pkg::PSPD_REF_1024;
      ref_pulse_q <= 1'b0;
    end else if (clk_en_in) begin
      if (ref_cnt_q == 11'h000) begin
        ref_cnt_q   <= ref_reload;
        ref_pulse_q <= 1'b1;
      end else begin
        ref_cnt_q   <= ref_cnt_q - 11'h001;
        ref_pulse_q <= 1'b0;
      end
    end
  end

  // Pin drivers. Outside test mode phase and lock pins are registered from the same state,
  // so they then change in the same cycle.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_detector_out      <= 1'b0;
      phase_detector_oe_n_out <= 1'b1;
      lock_oe_n_out           <= 1'b0;
    end else if (clk_en_in) begin
      if (test_in) begin
        phase_detector_out      <= fin_pulse_q;
        phase_detector_oe_n_out <= 1'b0;
        lock_oe_n_out           <= ref_pulse_q;
      end else begin
        phase_detector_out      <= (pd_state == pspd_pkg::PSPD_PD_LEAD);
        phase_detector_oe_n_out <= (pd_state == pspd_pkg::PSPD_PD_IDLE);
        lock_oe_n_out           <= (pd_state != pspd_pkg::PSPD_PD_IDLE);
      end
    end
  end

  // Lock tracking for status and events; follows the detector, not the test mux.
  assign lock_gain = ~locked_q & (pd_state == pspd_pkg::PSPD_PD_IDLE);
  assign lock_loss = locked_q & (pd_state != pspd_pkg::PSPD_PD_IDLE);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      locked_q <= 1'b0;
    end else if (clk_en_in) begin
      locked_q <= (pd_state == pspd_pkg::PSPD_PD_IDLE);
    end
  end

  // Bus decode. A request is answered one cycle after it appears; the write
  // and the read capture both happen on the edge that raises ack.
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign bus_wr  = bus_req & wb_we_in & wb_sel_in[0];
  assign irq_clr = (bus_wr && wb_adr_in == pspd_pkg::PSPD_OFS_IRQ_CLR) ?
                   wb_dat_in[pspd_pkg::PSPD_IRQ_W-1:0] : '0;

  // Events; a set in the same cycle as its clear wins.
  assign irq_ev[pspd_pkg::PSPD_IRQ_LOAD]    = load_pulse;
  assign irq_ev[pspd_pkg::PSPD_IRQ_LOCK]    = lock_gain;
  assign irq_ev[pspd_pkg::PSPD_IRQ_UNLOCK]  = lock_loss;
  assign irq_ev[pspd_pkg::PSPD_IRQ_IGNORED] = ignored_pulse;
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;

  // Sticky status and the level interrupt.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_st_q <= '0;
      irq_out  <= 1'b0;
    end else if (clk_en_in) begin
      irq_st_q <= irq_st_d;
      irq_out  <= |(irq_st_d & irq_en_q);
    end
  end

  // Software-written controls; the prescaler bit steers the swallow logic.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      presc_en_q <= 1'b0;
      irq_en_q   <= '0;
    end else if (clk_en_in && bus_wr) begin
      if (wb_adr_in == pspd_pkg::PSPD_OFS_CTRL) begin
        presc_en_q <= wb_dat_in[pspd_pkg::PSPD_CTRL_PRESC];
      end
      if (wb_adr_in == pspd_pkg::PSPD_OFS_IRQ_EN) begin
        irq_en_q <= wb_dat_in[pspd_pkg::PSPD_IRQ_W-1:0];
      end
    end
  end

  // Set once the first full sequence has been applied.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      loaded_q <= 1'b0;
    end else if (clk_en_in && load_pulse) begin
      loaded_q <= 1'b1;
    end
  end

  // Read multiplexer; unmapped and write-only addresses read as zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_in)
      pspd_pkg::PSPD_OFS_CTRL: begin
        rd_d[pspd_pkg::PSPD_CTRL_PRESC] = presc_en_q;
      end
      pspd_pkg::PSPD_OFS_STATUS: begin
        rd_d[0]   = loaded_q;
        rd_d[1]   = (pd_state == pspd_pkg::PSPD_PD_LEAD);
        rd_d[2]   = (pd_state == pspd_pkg::PSPD_PD_LAG);
        rd_d[3]   = locked_q;
        rd_d[6:4] = nib_count;
      end
      pspd_pkg::PSPD_OFS_SETTING: begin
        rd_d[3:0]   = setting.swallow;
        rd_d[15:4]  = n_bin;
        rd_d[17:16] = setting.ref_sel;
      end
      pspd_pkg::PSPD_OFS_IRQ_ST: begin
        rd_d[pspd_pkg::PSPD_IRQ_W-1:0] = irq_st_q;
      end
      pspd_pkg::PSPD_OFS_IRQ_EN: begin
        rd_d[pspd_pkg::PSPD_IRQ_W-1:0] = irq_en_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Acknowledge and read data; ack falls in the cycle after it was given.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      wb_ack_out <= bus_req;
      if (bus_req && !wb_we_in) begin
        wb_dat_out <= rd_d;
      end
    end
  end
endmodule

// file: pspd_top_assertions.sv
// Concurrent checks on the core pins: reset state, bus answer, detector, lock and test pins.
// Assumes one clock domain and clk_en_in held high while the bench runs.
`timescale 1ns/10ps
module pspd_top_checker (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic test_in,
  input  wire logic wb_cyc_in,
  input  wire logic wb_stb_in,
  input  wire logic wb_we_in,
  input  wire logic wb_ack_out,
  input  wire logic phase_detector_out,
  input  wire logic phase_detector_oe_n_out,
  input  wire logic lock_oe_n_out,
  input  wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // A request still waiting for its answer.
  sequence wb_req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  // The answer stands for exactly one cycle.
  sequence ack_pulse_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  // Pins leave reset with the detector floating and the lock pin pulled low.
  reset_vals_a: assert property ($rose(nrst_in) |-> !wb_ack_out && !irq_out
    && phase_detector_oe_n_out && !lock_oe_n_out) else $error("pins not idle after reset");
  wb_ack_a: assert property (wb_req_s |=> ack_pulse_s) else $error("bus answer late");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("answer without request");
  // Outside test mode the lock pin mirrors whether the detector drives.
  lock_pd_a: assert property (!$past(test_in) |-> lock_oe_n_out != phase_detector_oe_n_out)
    else $error("lock pin disagrees with detector");
  test_pd_a: assert property ($past(test_in) |-> !phase_detector_oe_n_out)
    else $error("detector pin floats in test mode");
  // In test mode the reference appears on the lock pin as a single-cycle pulse.
  test_lock_a: assert property (test_in [*2] ##0 lock_oe_n_out ##1 test_in |-> !lock_oe_n_out)
    else $error("reference pulse too wide");
  // A driven detector never swaps lead for lag without floating between them.
  pd_hold_a: assert property (!$past(test_in) && !$past(test_in, 2)
    && !phase_detector_oe_n_out && !$past(phase_detector_oe_n_out)
    |-> $stable(phase_detector_out)) else $error("detector flipped while driving");
  // Status is sticky, so only a bus write can lower the interrupt.
  // An enable write lowers it one cycle later than a clear, so both write cycles are excused.
  irq_hold_a: assert property (irq_out ##1 (!(wb_cyc_in && wb_we_in)
    && !$past(wb_cyc_in && wb_we_in)) |-> irq_out)
    else $error("interrupt fell without a write");
endmodule

bind pspd_top pspd_top_checker pspd_top_checker_i (
  .clk_in(clk_in), .nrst_in(nrst_in), .test_in(test_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_ack_out(wb_ack_out),
  .phase_detector_out(phase_detector_out), .phase_detector_oe_n_out(phase_detector_oe_n_out),
  .lock_oe_n_out(lock_oe_n_out), .irq_out(irq_out));

// file: pspd_far_model.sv
// Far side of the core: the host that loads nibbles and the dual-modulus prescaler.
// Assumes host and prescaler are timed from the core clock.
`timescale 1ns/10ps
module pspd_far_model (
  input  wire logic  clk_in,
  input  wire logic  run_in,
  input  wire logic  modulus_control_in,
  output logic       latch_reset_out,
  output logic       data_read_clock_out,
  output logic [3:0] data_out,
  output logic       count_out
);
  // The host rests with the latch reset high so a stray edge cannot load.
  initial begin
    latch_reset_out = 1'b1;
    data_read_clock_out = 1'b1;
    data_out = 4'h0;
    count_out = 1'b0;
  end
  // Sends k read clock pulses; a sixth pulse repeats the first nibble.
  task automatic send(input logic [19:0] nib, input int k, input logic hold);
    int j;
    @(posedge clk_in) latch_reset_out <= 1'b1;
    @(posedge clk_in) latch_reset_out <= hold;
    for (j = 0; j < k; j++) begin
      @(posedge clk_in) data_out <= nib[4*(j%5) +: 4];
      data_read_clock_out <= 1'b1;
      @(posedge clk_in) data_read_clock_out <= 1'b0;
      @(posedge clk_in) data_out <= ~data_out; // Lines are not held past the capture.
    end
  endtask
  // Output period is ten cycles, eleven while the modulus asks for it; read mid-period.
  always begin
    @(posedge clk_in);
    if (run_in) begin
      count_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      count_out <= 1'b0;
      repeat (modulus_control_in ? 5 : 4) @(posedge clk_in);
    end
  end
endmodule

// file: pspd_top_tb.sv
// Self-checking bench of the core: loads, register bus, interrupts and divider timing.
// Assumes the far-side model and the checker are compiled before it.
`timescale 1ns/10ps
module pspd_top_tb;
  logic        clk_in, nrst_in, test_in, run, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        pd, pd_oe_n, lock_oe_n, modc, irq, lr, rc, cnt;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, dat;
  logic [31:0] wb_wdat, wb_rdat, q;
  int          num_errors, compares, seed, cycles, a, n, g, i;

  pspd_top pspd_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(1'b1),
    .latch_reset_in(lr), .data_read_clock_in(rc), .data_in(dat), .test_in(test_in),
    .count_in(cnt), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .phase_detector_out(pd), .phase_detector_oe_n_out(pd_oe_n),
    .lock_oe_n_out(lock_oe_n), .modulus_control_out(modc), .irq_out(irq));
  pspd_far_model pspd_far_model_i (.clk_in(clk_in), .run_in(run), .modulus_control_in(modc),
    .latch_reset_out(lr), .data_read_clock_out(rc), .data_out(dat), .count_out(cnt));

  // Clock at 25 MHz and a free cycle count for measuring pulse spacing.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cycles <= cycles + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle; read data lands in q at the answering edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    wb_sel <= 4'hF;
    do @(posedge clk_in); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, adr, 32'h0);
    check(q & m, e);
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk_in);
    check(32'(irq), 32'(e));
  endtask
  // Spacing in cycles of the last two of three pulses on the lock or detector pin.
  task automatic gap(input logic on_lock);
    int k, t0;
    t0 = 0;
    for (k = 0; k < 3; k++) begin
      do @(posedge clk_in); while ((on_lock ? lock_oe_n : pd) !== 1'b1);
      g = cycles - t0;
      t0 = cycles;
    end
  endtask
  function automatic int ratio(input int s);
    ratio = (s == 0) ? 1024 : (s == 1) ? 1000 : (s == 2) ? 100 : 20;
  endfunction
  function automatic logic [19:0] enc(input int a, input int n, input int s);
    enc = {2'(s), 2'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10), 4'(a)};
  endfunction
  function automatic logic [31:0] sval(input int a, input int n, input int s);
    sval = {14'h0, 2'(s), 12'(n), 4'(a)};
  endfunction
  task automatic load(input int a, input int n, input int s, input int k, input logic h);
    pspd_far_model_i.send(enc(a, n, s), k, h);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Budget is about three times the expected run, which is dominated by divider pulses.
  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    seed = 76;
    cycles = 0;
    nrst_in = 1'b0;
    test_in = 1'b0;
    run = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    check(32'({lock_oe_n, pd_oe_n}), 32'h1);
    rd(pspd_pkg::PSPD_OFS_SETTING, 32'hFFFFFFFF, sval(0, 20, 0));
    rd(8'h18, 32'hFFFFFFFF, 32'h0);
    $display("reset test done");
    // Random loads with N at both ends of its legal range and A at the top of its range.
    wb(1'b1, pspd_pkg::PSPD_OFS_IRQ_EN, 32'h1);
    for (i = 0; i < 4; i++) begin
      a = $unsigned($random(seed)) % 10;
      n = (i == 0) ? 20 : (i == 3) ? 3999 : 20 + $unsigned($random(seed)) % 3980;
      a = (i == 3) ? 9 : a;
      load(a, n, i, 5, 1'b0);
      rd(pspd_pkg::PSPD_OFS_SETTING, 32'hFFFFFFFF, sval(a, n, i));
      check(32'(irq), 32'h1);
      wb(1'b1, pspd_pkg::PSPD_OFS_IRQ_CLR, 32'hF);
    end
    $display("load test done");
    // Aborted frame restarts; then mask, unmask and clear the load event.
    load(3, 456, 1, 3, 1'b0);
    load(7, 1234, 2, 5, 1'b0);
    rd(pspd_pkg::PSPD_OFS_SETTING, 32'hFFFFFFFF, sval(7, 1234, 2));
    wb(1'b1, pspd_pkg::PSPD_OFS_IRQ_EN, 32'h0);
    irq_is(1'b0);
    wb(1'b1, pspd_pkg::PSPD_OFS_IRQ_EN, 32'h1);
    irq_is(1'b1);
    wb(1'b1, pspd_pkg::PSPD_OFS_IRQ_CLR, 32'h1);
    irq_is(1'b0);
    rd(pspd_pkg::PSPD_OFS_IRQ_ST, 32'h1, 32'h0);
    load(5, 876, 3, 5, 1'b1);
    rd(pspd_pkg::PSPD_OFS_SETTING, 32'hFFFFFFFF, sval(7, 1234, 2));
    irq_is(1'b0);
    load(2, 345, 0, 6, 1'b0);
    rd(pspd_pkg::PSPD_OFS_SETTING, 32'hFFFFFFFF, sval(2, 345, 0));
    rd(pspd_pkg::PSPD_OFS_IRQ_ST, 32'h9, 32'h9);
    rd(pspd_pkg::PSPD_OFS_STATUS, 32'h71, 32'h51);
    $display("frame test done");
    // Test mode exposes both dividers; odd passes enable the prescaler.
    test_in <= 1'b1;
    run <= 1'b1;
    for (i = 0; i < 4; i++) begin
      a = $unsigned($random(seed)) % 10;
      n = 20 + $unsigned($random(seed)) % 60;
      wb(1'b1, pspd_pkg::PSPD_OFS_CTRL, 32'(i % 2));
      load(a, n, i, 5, 1'b0);
      gap(1'b1);
      check(32'(g), 32'(ratio(i)));
      gap(1'b0);
      check(32'(g), 32'((i % 2) ? 10 * n + a : 10 * n));
      check(32'({pd_oe_n, (i % 2 == 0) && modc}), 32'h0);
    end
    $display("divider test done");
    // A fast divided input leads a slow reference; a stopped one lags it.
    test_in <= 1'b0;
    wb(1'b1, pspd_pkg::PSPD_OFS_CTRL, 32'h0);
    load(0, 20, 0, 5, 1'b0);
    repeat (2100) @(posedge clk_in);
    do @(posedge clk_in); while (pd_oe_n !== 1'b0);
    check(32'({pd, lock_oe_n}), 32'h3);
    run <= 1'b0;
    repeat (2100) @(posedge clk_in);
    check(32'({pd, pd_oe_n, lock_oe_n}), 32'h1);
    rd(pspd_pkg::PSPD_OFS_IRQ_ST, 32'h6, 32'h6);
    $display("detector test done");
    results();
  end
endmodule
